// file: src/sfham_top.v
// SPI slave of a serial flash with a pause input, over the byte array.
// Assumes cs_n, sclk, hold_n and serial_in are asynchronous to sys_clk, srst is synchronous to it, and sclk is far slower than sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "sfham_defs.vh"

module sfham_top (
  input wire sys_clk,
  input wire srst,
  input wire cs_n,
  input wire sclk,
  input wire hold_n,
  input wire serial_in,
  output reg serial_out,
  output wire serial_out_oe,
  output wire write_busy
);

  localparam [3:0] ST_CMD = 4'b0001;
  localparam [3:0] ST_ADDR = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_IGNORE = 4'b1000;

  reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  reg cs_s1_reg, cs_s2_reg;
  reg hold_s1_reg, hold_s2_reg;
  reg si_s1_reg, si_s2_reg;
  reg hold_active_reg;
  reg [3:0] state_reg;
  reg [7:0] cmd_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg [1:0] addr_cnt_reg;
  reg [23:0] addr_reg;
  reg [7:0] out_shift_reg;
  reg drive_reg;
  reg ld1_reg, ld2_reg;
  reg wr_en_reg;
  reg [22:0] wr_addr_reg;
  reg [7:0] wr_data_reg;
  reg erase_start_reg;
  reg [1:0] erase_kind_reg;

  wire selected;
  wire sclk_rise;
  wire sclk_fall;
  wire [7:0] byte_in;
  wire byte_done;
  wire is_read;
  wire is_prog;
  wire is_otp;
  wire [7:0] rd_data;
  wire busy;

  function [14:0] page_of;
    input [22:0] a;
    begin
      page_of = a[22:`SFHAM_PAGE_LSB];
    end
  endfunction

  // Command decode, shared by the byte that ends a command and the held command.
  function op_needs_addr;
    input [7:0] op;
    begin
      case (op)
        `SFHAM_CMD_READ: op_needs_addr = 1'b1;
        `SFHAM_CMD_PROG: op_needs_addr = 1'b1;
        `SFHAM_CMD_SUB_ERASE: op_needs_addr = 1'b1;
        `SFHAM_CMD_SECT_ERASE: op_needs_addr = 1'b1;
        `SFHAM_CMD_OTP_READ: op_needs_addr = 1'b1;
        `SFHAM_CMD_OTP_PROG: op_needs_addr = 1'b1;
        default: op_needs_addr = 1'b0;
      endcase
    end
  endfunction

  function op_reads;
    input [7:0] op;
    begin
      case (op)
        `SFHAM_CMD_READ: op_reads = 1'b1;
        `SFHAM_CMD_OTP_READ: op_reads = 1'b1;
        default: op_reads = 1'b0;
      endcase
    end
  endfunction

  function op_programs;
    input [7:0] op;
    begin
      case (op)
        `SFHAM_CMD_PROG: op_programs = 1'b1;
        `SFHAM_CMD_OTP_PROG: op_programs = 1'b1;
        default: op_programs = 1'b0;
      endcase
    end
  endfunction

  function op_otp;
    input [7:0] op;
    begin
      case (op)
        `SFHAM_CMD_OTP_READ: op_otp = 1'b1;
        `SFHAM_CMD_OTP_PROG: op_otp = 1'b1;
        default: op_otp = 1'b0;
      endcase
    end
  endfunction

  // Two-stage synchronisers; sclk has a third stage for edge detection.
  always @(posedge sys_clk) begin
    if (srst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      hold_s1_reg <= 1'b1;
      hold_s2_reg <= 1'b1;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      hold_s1_reg <= hold_n;
      hold_s2_reg <= hold_s1_reg;
      si_s1_reg <= serial_in;
      si_s2_reg <= si_s1_reg;
    end
  end

  assign selected = ~cs_s2_reg;
  assign write_busy = busy;

  // Pause changes only while the clock is low, so an edge seen with the
  // clock high takes effect when the clock next falls.
  always @(posedge sys_clk) begin
    if (srst || !selected) begin
      hold_active_reg <= 1'b0;
    end else if (!sclk_s2_reg) begin
      hold_active_reg <= ~hold_s2_reg;
    end
  end

  // Clock edges are dropped while paused; all shift state is kept.
  assign sclk_rise = selected & ~hold_active_reg & sclk_s2_reg & ~sclk_s3_reg;
  assign sclk_fall = selected & ~hold_active_reg & ~sclk_s2_reg & sclk_s3_reg;
  assign byte_in = {shift_reg[6:0], si_s2_reg};
  assign byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
  assign is_read = op_reads(cmd_reg);
  assign is_prog = op_programs(cmd_reg);
  assign is_otp = op_otp(cmd_reg);
  assign serial_out_oe = selected & ~hold_active_reg & drive_reg;

  always @(posedge sys_clk) begin
    if (srst || !selected) begin
      // Deselect, paused or not, discards any partial instruction.
      state_reg <= ST_CMD;
      cmd_reg <= 8'h00;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      addr_cnt_reg <= 2'h0;
      addr_reg <= 24'h000000;
      drive_reg <= 1'b0;
      ld1_reg <= 1'b0;
      ld2_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 23'h000000;
      wr_data_reg <= 8'h00;
      erase_start_reg <= 1'b0;
      erase_kind_reg <= `SFHAM_ERASE_SUB;
    end else begin
      wr_en_reg <= 1'b0;
      erase_start_reg <= 1'b0;
      ld1_reg <= 1'b0;
      ld2_reg <= ld1_reg;
      if (sclk_rise) begin
        shift_reg <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      if (byte_done) begin
        case (state_reg)
          ST_CMD: begin
            cmd_reg <= byte_in;
            addr_cnt_reg <= 2'h0;
            if (byte_in == `SFHAM_CMD_STATUS) begin
              state_reg <= ST_DATA;
              ld1_reg <= 1'b1;
            end else if (busy) begin
              state_reg <= ST_IGNORE;
            end else if (byte_in == `SFHAM_CMD_BULK_ERASE) begin
              erase_start_reg <= 1'b1;
              erase_kind_reg <= `SFHAM_ERASE_BULK;
              state_reg <= ST_IGNORE;
            end else if (op_needs_addr(byte_in)) begin
              state_reg <= ST_ADDR;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            addr_reg <= {addr_reg[15:0], byte_in};
            addr_cnt_reg <= addr_cnt_reg + 2'h1;
            if (addr_cnt_reg == 2'h2) begin
              if (cmd_reg == `SFHAM_CMD_SUB_ERASE) begin
                erase_start_reg <= 1'b1;
                erase_kind_reg <= `SFHAM_ERASE_SUB;
                state_reg <= ST_IGNORE;
              end else if (cmd_reg == `SFHAM_CMD_SECT_ERASE) begin
                erase_start_reg <= 1'b1;
                erase_kind_reg <= `SFHAM_ERASE_SECT;
                state_reg <= ST_IGNORE;
              end else begin
                state_reg <= ST_DATA;
                ld1_reg <= is_read;
              end
            end
          end
          ST_DATA: begin
            if (is_prog) begin
              wr_en_reg <= 1'b1;
              wr_addr_reg <= addr_reg[22:0];
              wr_data_reg <= byte_in;
              // The byte pointer wraps inside the 256-byte page being programmed, or inside the 64-byte OTP area.
              if (is_otp) begin
                addr_reg <= {18'h00000, addr_reg[5:0] + 6'h01};
              end else begin
                addr_reg <= {1'b0, page_of(addr_reg[22:0]), addr_reg[7:0] + 8'h01};
              end
            end else begin
              if (is_otp) begin
                addr_reg <= {18'h00000, addr_reg[5:0] + 6'h01};
              end else begin
                addr_reg <= {1'b0, addr_reg[22:0] + 23'h000001};
              end
              ld1_reg <= 1'b1;
            end
          end
          default: begin
            state_reg <= ST_IGNORE;
          end
        endcase
      end
      if (ld2_reg) begin
        drive_reg <= 1'b1;
      end
    end
  end

  // Output byte is loaded two cycles after a byte ends and shifted on falling clock.
  always @(posedge sys_clk) begin
    if (srst || !selected) begin
      out_shift_reg <= 8'h00;
      serial_out <= 1'b0;
    end else if (ld2_reg) begin
      if (cmd_reg == `SFHAM_CMD_STATUS) begin
        out_shift_reg <= {7'h00, busy};
      end else begin
        out_shift_reg <= rd_data;
      end
    end else if (sclk_fall && drive_reg) begin
      serial_out <= out_shift_reg[7];
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
    end
  end

  sfham_array u_array (
    .sys_clk(sys_clk),
    .srst(srst),
    .rd_addr(addr_reg[22:0]),
    .rd_otp(is_otp),
    .rd_data(rd_data),
    .wr_en(wr_en_reg),
    .wr_otp(is_otp),
    .wr_addr(wr_addr_reg),
    .wr_data(wr_data_reg),
    .erase_start(erase_start_reg),
    .erase_kind(erase_kind_reg),
    .erase_addr(addr_reg[22:0]),
    .busy(busy)
  );

endmodule // sfham_top

`default_nettype wire

// file: src/sfham_defs.vh
// Constants for the serial flash commands, erase kinds and main array map.
// Included by every design file; holds definitions only.
`ifndef SFHAM_DEFS_VH
`define SFHAM_DEFS_VH

`define SFHAM_ADDR_W 23
`define SFHAM_ARRAY_BYTES 8388608
`define SFHAM_OTP_BYTES 64
`define SFHAM_OTP_AW 6
`define SFHAM_PAGE_BYTES 256
`define SFHAM_SUBSECTOR_BYTES 24'h001000
`define SFHAM_SECTOR_BYTES 24'h010000
`define SFHAM_BULK_BYTES 24'h800000
`define SFHAM_NUM_SUBSECTORS 2048
`define SFHAM_NUM_SECTORS 128
`define SFHAM_NUM_PAGES 32768
`define SFHAM_SECTOR_LSB 16
`define SFHAM_SUBSECTOR_LSB 12
`define SFHAM_PAGE_LSB 8
`define SFHAM_ERASED_BYTE 8'hff

`define SFHAM_ERASE_SUB 2'h0
`define SFHAM_ERASE_SECT 2'h1
`define SFHAM_ERASE_BULK 2'h2

`define SFHAM_CMD_READ 8'h03
`define SFHAM_CMD_PROG 8'h02
`define SFHAM_CMD_SUB_ERASE 8'h20
`define SFHAM_CMD_SECT_ERASE 8'hd8
`define SFHAM_CMD_BULK_ERASE 8'hc7
`define SFHAM_CMD_STATUS 8'h05
`define SFHAM_CMD_OTP_READ 8'h4b
`define SFHAM_CMD_OTP_PROG 8'h42

`endif

// file: src/sfham_array.v
// Main array of bytes, the separate one-time-programmable area and the erase engine.
// Assumes write and erase requests come from logic on sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "sfham_defs.vh"

module sfham_array (
  input wire sys_clk,
  input wire srst,
  input wire [22:0] rd_addr,
  input wire rd_otp,
  output reg [7:0] rd_data,
  input wire wr_en,
  input wire wr_otp,
  input wire [22:0] wr_addr,
  input wire [7:0] wr_data,
  input wire erase_start,
  input wire [1:0] erase_kind,
  input wire [22:0] erase_addr,
  output wire busy
);

  reg [7:0] mem [0:`SFHAM_ARRAY_BYTES-1];
  reg [7:0] otp [0:`SFHAM_OTP_BYTES-1];
  reg [22:0] er_ptr_reg;
  reg [23:0] er_left_reg;
  integer i;

  function [6:0] sector_of;
    input [22:0] a;
    begin
      sector_of = a[22:`SFHAM_SECTOR_LSB];
    end
  endfunction

  function [10:0] subsector_of;
    input [22:0] a;
    begin
      subsector_of = a[22:`SFHAM_SUBSECTOR_LSB];
    end
  endfunction

  // The array starts erased so that a simulation need not bulk erase first.
  initial begin
    for (i = 0; i < `SFHAM_ARRAY_BYTES; i = i + 1) begin
      mem[i] = `SFHAM_ERASED_BYTE;
    end
    for (i = 0; i < `SFHAM_OTP_BYTES; i = i + 1) begin
      otp[i] = `SFHAM_ERASED_BYTE;
    end
  end

  assign busy = (er_left_reg != 24'h000000);

  // Reads are linear from zero; the OTP area has its own address space.
  always @(posedge sys_clk) begin
    if (rd_otp) begin
      rd_data <= otp[rd_addr[`SFHAM_OTP_AW-1:0]];
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      er_ptr_reg <= 23'h000000;
      er_left_reg <= 24'h000000;
    end else if (busy) begin
      // One byte is returned to all ones per cycle.
      mem[er_ptr_reg] <= `SFHAM_ERASED_BYTE;
      er_ptr_reg <= er_ptr_reg + 23'h000001;
      er_left_reg <= er_left_reg - 24'h000001;
    end else if (erase_start) begin
      case (erase_kind)
        `SFHAM_ERASE_SUB: begin
          er_ptr_reg <= {subsector_of(erase_addr), 12'h000};
          er_left_reg <= `SFHAM_SUBSECTOR_BYTES;
        end
        `SFHAM_ERASE_SECT: begin
          er_ptr_reg <= {sector_of(erase_addr), 16'h0000};
          er_left_reg <= `SFHAM_SECTOR_BYTES;
        end
        default: begin
          er_ptr_reg <= 23'h000000;
          er_left_reg <= `SFHAM_BULK_BYTES;
        end
      endcase
    end else if (wr_en) begin
      // Programming can only clear bits.
      if (wr_otp) begin
        otp[wr_addr[`SFHAM_OTP_AW-1:0]] <= otp[wr_addr[`SFHAM_OTP_AW-1:0]] & wr_data;
      end else begin
        mem[wr_addr] <= mem[wr_addr] & wr_data;
      end
    end
  end

endmodule // sfham_array

`default_nettype wire

// file: tb/sfham_assertions.sv
// Checker for pause, select and erase timing at the flash top's ports.
// Sees only the top's pins; pin paths carry 2 to 3 sys_clk of sync delay.
`timescale 1ns/10ps
`default_nettype none
module sfham_checker (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic hold_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic write_busy
);
  logic [23:0] busy_cnt_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  always @(posedge sys_clk) begin
    if (srst || !write_busy) begin
      busy_cnt_reg <= 24'h000000;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 24'h000001;
    end
  end
  a_oe_deselect: assert property (cs_n [*6] |-> !serial_out_oe)
    else $error("output enabled while deselected");
  a_hold_floats: assert property ((!hold_n && !sclk && !cs_n) [*6] |-> !serial_out_oe)
    else $error("output driven while paused");
  a_hold_enter: assert property ($fell(hold_n) && !cs_n && !sclk && !$past(sclk, 4)
    |-> ##[1:5] !serial_out_oe) else $error("pause not entered");
  a_enter_defer: assert property ($fell(hold_n) && sclk && $past(sclk, 4) && !cs_n
    && serial_out_oe ##1 sclk [*5] |-> serial_out_oe) else $error("pause entered early");
  a_leave_defer: assert property ($rose(hold_n) && sclk && $past(sclk, 4) && !cs_n
    && !serial_out_oe ##1 sclk [*5] |-> !serial_out_oe) else $error("pause left early");
  a_out_frozen: assert property ((!hold_n && !sclk && !cs_n) [*6] ##1 (!hold_n && !cs_n)
    |-> $stable(serial_out)) else $error("output moved while paused");
  a_oe_needs_sel: assert property (serial_out_oe |-> !$past(cs_n, 2))
    else $error("output enabled without select");
  a_busy_len: assert property ($fell(write_busy) |-> busy_cnt_reg == 24'h001000
    || busy_cnt_reg == 24'h010000 || busy_cnt_reg == 24'h800000) else $error("bad erase length");
endmodule // sfham_checker
bind sfham_top sfham_checker u_sfham_checker (.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n),
  .sclk(sclk), .hold_n(hold_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .write_busy(write_busy));
`default_nettype wire

// file: tb/sfham_host.sv
// Bus host model: select, serial clock, pause and data into the flash.
// Assumes the bench's sys_clk; pins change at its falling edge, clock period 16 cycles.
`timescale 1ns/10ps
`default_nettype none
module sfham_host (
  input wire logic sys_clk,
  input wire logic dq_line,
  output logic cs_n,
  output logic sclk,
  output logic hold_n,
  output logic serial_in
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hold_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic set_sel(input logic v);
    wait_clk(4);
    if (v) begin
      hold_n = 1'b1;
      wait_clk(4);
    end
    cs_n = !v;
    serial_in = !serial_in;
    wait_clk(8);
  endtask
  task automatic set_pin(input logic clk_v, input logic hold_v);
    sclk = clk_v;
    hold_n = hold_v;
    wait_clk(8);
  endtask
  // Mode 0, most significant bit first; the reply is sampled at each rising edge.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      wait_clk(8);
      sclk = 1'b1;
      rx[i] = dq_line;
      wait_clk(8);
      sclk = 1'b0;
    end
    // The clock rests low for a half period, so the next caller never retimes it at once.
    wait_clk(8);
  endtask
endmodule // sfham_host
`default_nettype wire

// file: tb/sfham_top_tb.sv
// Self-checking bench for the serial flash top with its pause input.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module sfham_top_tb;
  logic sys_clk, srst;
  wire cs_n, sclk, hold_n, serial_in, serial_out, serial_out_oe, write_busy, dq_line;
  int num_errors = 0;
  int tests_run = 0;
  assign dq_line = serial_out_oe ? serial_out : 1'bz;
  sfham_top u_sfham_top (.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
    .hold_n(hold_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .write_busy(write_busy));
  sfham_host u_sfham_host (.sys_clk(sys_clk), .dq_line(dq_line), .cs_n(cs_n), .sclk(sclk),
    .hold_n(hold_n), .serial_in(serial_in));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start_op(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] d;
    u_sfham_host.set_sel(1'b1);
    u_sfham_host.xfer(op, d);
    u_sfham_host.xfer(a[23:16], d);
    u_sfham_host.xfer(a[15:8], d);
    u_sfham_host.xfer(a[7:0], d);
  endtask
  task automatic rw(input logic [7:0] op, input logic [23:0] a, input logic [15:0] w);
    logic [7:0] d;
    logic rd_op;
    rd_op = (op == 8'h03) || (op == 8'h4b) || (op == 8'h05);
    start_op(op, a);
    u_sfham_host.xfer(w[15:8], d);
    if (rd_op) begin
      check("read byte 0", w[15:8], d);
    end
    u_sfham_host.xfer(w[7:0], d);
    if (rd_op) begin
      check("read byte 1", w[7:0], d);
    end
    u_sfham_host.set_sel(1'b0);
  endtask
  task automatic t_map();
    rw(8'h02, 24'h1230ff, 16'ha53c);
    rw(8'h03, 24'h123000, 16'h3cff);
    rw(8'h02, 24'h1230ff, 16'hf0ff);
    rw(8'h03, 24'h1230ff, 16'ha0ff);
    rw(8'h02, 24'h7fffff, 16'h1100);
    rw(8'h03, 24'h7fffff, 16'h11ff);
    rw(8'h42, 24'h000000, 16'h5ac3);
    rw(8'h4b, 24'h000000, 16'h5ac3);
    rw(8'h03, 24'h000000, 16'hffff);
    $display("map test done");
  endtask
  task automatic t_pause();
    logic [7:0] d;
    start_op(8'h03, 24'h1230ff);
    check("oe before pause", 8'h01, {7'h00, serial_out_oe});
    u_sfham_host.set_pin(1'b0, 1'b0);
    check("oe in pause", 8'h00, {7'h00, serial_out_oe});
    u_sfham_host.set_pin(1'b1, 1'b0);
    u_sfham_host.set_pin(1'b0, 1'b0);
    u_sfham_host.set_pin(1'b0, 1'b1);
    u_sfham_host.xfer(8'h00, d);
    check("byte after pause", 8'ha0, d);
    u_sfham_host.set_sel(1'b0);
    $display("pause test done");
  endtask
  task automatic wait_idle(input int limit);
    int n;
    n = 0;
    while (write_busy !== 1'b0) begin
      @(negedge sys_clk);
      n++;
      if (n > limit) begin
        num_errors++;
        $display("ERROR erase wait expected done seen busy");
        final_report();
      end
    end
  endtask
  task automatic t_erase_defer();
    logic [7:0] d;
    start_op(8'h20, 24'h123456);
    u_sfham_host.set_sel(1'b0);
    rw(8'h05, 24'h000000, 16'h0101);
    start_op(8'h05, 24'h000000);
    u_sfham_host.set_pin(1'b1, 1'b1);
    u_sfham_host.set_pin(1'b1, 1'b0);
    check("oe deferred entry", 8'h01, {7'h00, serial_out_oe});
    u_sfham_host.set_pin(1'b0, 1'b0);
    check("oe after entry", 8'h00, {7'h00, serial_out_oe});
    u_sfham_host.set_pin(1'b1, 1'b0);
    u_sfham_host.set_pin(1'b1, 1'b1);
    check("oe deferred exit", 8'h00, {7'h00, serial_out_oe});
    u_sfham_host.set_pin(1'b0, 1'b1);
    check("oe after exit", 8'h01, {7'h00, serial_out_oe});
    check("busy in pause", 8'h01, {7'h00, write_busy});
    u_sfham_host.set_sel(1'b0);
    wait_idle(5000);
    rw(8'h05, 24'h000000, 16'h0000);
    rw(8'h03, 24'h1230ff, 16'hffff);
    rw(8'h03, 24'h7fffff, 16'h11ff);
    rw(8'h02, 24'h130000, 16'h00ff);
    rw(8'h02, 24'h12ffff, 16'h0000);
    start_op(8'hd8, 24'h12abcd);
    u_sfham_host.set_sel(1'b0);
    wait_idle(70000);
    rw(8'h03, 24'h12ffff, 16'hff00);
    rw(8'h03, 24'h12ff00, 16'hffff);
    $display("erase test done");
  endtask
  task automatic t_desel();
    logic [7:0] d;
    u_sfham_host.set_sel(1'b1);
    u_sfham_host.xfer(8'h02, d);
    u_sfham_host.set_pin(1'b0, 1'b0);
    u_sfham_host.set_sel(1'b0);
    rw(8'h03, 24'h000003, 16'hffff);
    $display("deselect test done");
  endtask
  task automatic final_report();
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end
  initial begin
    srst = 1'b1;
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    check("busy after reset", 8'h00, {7'h00, write_busy});
    t_map();
    t_pause();
    t_erase_defer();
    t_desel();
    final_report();
  end
endmodule // sfham_top_tb
`default_nettype wire
